// ### src/msd_pkg.sv
// constants, codes and state type of the measurement scaling datapath
// assumes currents arrive in microamps and percentages in 0.1 % steps
`default_nettype none

package msd_pkg;

    // ----------------------------------------------------------------
    // input ranges, microamps
    // ----------------------------------------------------------------
    localparam logic [15:0] OFS_4_20_UA = 16'h0FA0;
    localparam logic [15:0] SPAN_4_20_UA = 16'h3E80;
    localparam logic [15:0] SPAN_0_20_UA = 16'h4E20;
    localparam logic [15:0] TOP_UA = 16'h4E20;
    // 100.0 % in 0.1 % steps; also x full scale of user points
    localparam int X_FULL = 1000;

    // ----------------------------------------------------------------
    // fixed point and sequencing
    // ----------------------------------------------------------------
    localparam int FRAC_W = 16;
    localparam logic [5:0] DIV_STEPS = 6'h30;
    localparam logic [5:0] SQRT_STEPS = 6'h18;
    localparam int PTS_MIN = 2;
    localparam int PTS_MAX = 20;

    // ----------------------------------------------------------------
    // characteristic select
    // ----------------------------------------------------------------
    localparam logic [1:0] CHAR_LIN = 2'h0;
    localparam logic [1:0] CHAR_SQR = 2'h1;
    localparam logic [1:0] CHAR_SQRT = 2'h2;
    localparam logic [1:0] CHAR_USER = 2'h3;

    // ----------------------------------------------------------------
    // measurement status codes
    // ----------------------------------------------------------------
    localparam logic [7:0] STAT_VALID = 8'h00;
    localparam logic [7:0] STAT_ABOVE = 8'hA0;
    localparam logic [7:0] STAT_BELOW = 8'h60;
    localparam logic [7:0] STAT_FAULT = 8'hC0;
    localparam logic [7:0] STAT_USR_ERR = 8'h10;
    localparam logic [7:0] STAT_WAIT = 8'h20;

    typedef enum logic [2:0] {
        FSM_IDLE,
        FSM_NORM,
        FSM_POST,
        FSM_SQRT,
        FSM_INTERP,
        FSM_FINISH
    } msd_fsm_t;

endpackage : msd_pkg

`default_nettype wire

// ### src/msd_scaling_datapath.sv
// measurement scaling datapath: current sample to displayed value
// assumes samples, fault flags and settings come from logic on I_CORE_CLK
// Overview of operation
// - alarm lamp on range exit or sensor fault
// - 4-20 mode: subtract 4 mA, divide by 16
// - 0-20 mode: divide by 20 mA, no offset
// - no clamping outside nominal span
// - linear: norm times span plus low value
// - low value above high inverts characteristic
// - square: norm squared then linear scaling
// - square root: root of norm then scaling
// - negative norm under root gives low value
// - user table of 2 to 20 points
// - pick segment bracketing the normalized result
// - interpolate with slope times 100 plus low y
// - beyond table, extrapolate outermost segment
// - permissible bounds from extension percentages
// - report status code per measurement
`default_nettype none

module msd_scaling_datapath #(
    parameter int PTS_MAX = msd_pkg::PTS_MAX
) (
    // clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // sample from the front end
    input wire logic I_SAMPLE_VALID,
    input wire logic [15:0] I_CURRENT_UA,
    input wire logic I_SENSOR_SHORT,
    input wire logic I_SENSOR_OPEN,
    // configuration
    input wire logic I_MODE_4_20,
    input wire logic [1:0] I_CHAR_SEL,
    input wire logic [15:0] I_CHARACTERISTIC_LOW_VALUE,
    input wire logic [15:0] I_CHARACTERISTIC_HIGH_VALUE,
    input wire logic [9:0] I_RANGE_LOW_EXTENSION_PCT,
    input wire logic [9:0] I_RANGE_HIGH_EXTENSION_PCT,
    // user characteristic table
    input wire logic [4:0] I_POINT_COUNT,
    input wire logic I_POINT_WR,
    input wire logic [4:0] I_POINT_IDX,
    input wire logic [9:0] I_POINT_X,
    input wire logic [15:0] I_POINT_Y,
    // results
    output logic [15:0] O_VALUE,
    output logic [31:0] O_NORMALIZED,
    output logic [7:0] O_STATUS,
    output logic O_ALARM_LAMP,
    output logic O_DONE,
    output logic O_BUSY
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        msd_pkg::msd_fsm_t st;
        logic mode_4_20;
        logic [1:0] char_sel;
        logic signed [15:0] lo_c;
        logic signed [15:0] hi_c;
        logic signed [16:0] diff_ua;
        logic [7:0] range_st;
        logic usr_err;
        logic signed [31:0] norm;
        logic [47:0] div_q;
        logic [32:0] div_r;
        logic [31:0] div_d;
        logic div_neg;
        logic [5:0] cnt;
        logic [47:0] rad;
        logic [23:0] root;
        logic signed [15:0] ypl;
        logic [PTS_MAX-1:0][9:0] pt_x;
        logic [PTS_MAX-1:0][15:0] pt_y;
        logic signed [15:0] value;
        logic [7:0] status;
        logic alarm;
        logic done;
        logic busy;
    } msd_state_t;

    localparam msd_state_t RST_VAL = '{
        st: msd_pkg::FSM_IDLE,
        status: msd_pkg::STAT_WAIT,
        default: '0
    };

    msd_state_t cur_reg;
    msd_state_t cur_next;

    // ----------------------------------------------------------------
    // arithmetic helpers
    // ----------------------------------------------------------------
    function automatic logic signed [15:0] msd_sat16(
        input logic signed [63:0] v
    );
        if (v > 64'sh7FFF)
            return 16'sh7FFF;
        if (v < -64'sh8000)
            return 16'sh8000;
        return v[15:0];
    endfunction : msd_sat16

    // f is q16; span is signed so low above high simply inverts
    function automatic logic signed [15:0] msd_scale(
        input logic signed [31:0] f,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        logic signed [16:0] span;
        logic signed [63:0] p;
        span = 17'(hi) - 17'(lo);
        p = 64'(f) * 64'(span);
        p = (p + 64'sh8000) >>> msd_pkg::FRAC_W;
        return msd_sat16(p + 64'(lo));
    endfunction : msd_scale

    // ----------------------------------------------------------------
    // capture decode
    // ----------------------------------------------------------------
    logic signed [16:0] cap_diff;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic [7:0] range_code;
    logic capture;

    assign capture = cur_reg.st == msd_pkg::FSM_IDLE && I_SAMPLE_VALID;
    assign cap_diff = signed'(17'(I_CURRENT_UA)) - (I_MODE_4_20 ?
        signed'(17'(msd_pkg::OFS_4_20_UA)) : 17'sh00000);
    assign lim_lo = I_MODE_4_20 ? 32'(msd_pkg::OFS_4_20_UA) -
        32'(msd_pkg::OFS_4_20_UA) * 32'(I_RANGE_LOW_EXTENSION_PCT) /
        32'(msd_pkg::X_FULL) : 32'h0;
    assign lim_hi = 32'(msd_pkg::TOP_UA) + 32'(msd_pkg::TOP_UA) *
        32'(I_RANGE_HIGH_EXTENSION_PCT) / 32'(msd_pkg::X_FULL);
    assign range_code = (I_SENSOR_SHORT || I_SENSOR_OPEN) ?
        msd_pkg::STAT_FAULT : 32'(I_CURRENT_UA) > lim_hi ?
        msd_pkg::STAT_ABOVE : 32'(I_CURRENT_UA) < lim_lo ?
        msd_pkg::STAT_BELOW : msd_pkg::STAT_VALID;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [32:0] rs;
        logic signed [48:0] res;
        logic signed [63:0] num;
        logic signed [63:0] sq;
        logic [63:0] mag;
        logic [4:0] k;
        logic [4:0] ph;
        logic signed [10:0] xdiff;
        logic signed [16:0] ydiff;
        logic [23:0] trial;
        logic [15:0] span;
        logic usr_bad;
        rs = {cur_reg.div_r[31:0], cur_reg.div_q[47]};
        res = '0;
        mag = '0;
        span = I_MODE_4_20 ? msd_pkg::SPAN_4_20_UA : msd_pkg::SPAN_0_20_UA;
        trial = cur_reg.root | (24'h000001 << (cur_reg.cnt - 6'h01));
        sq = (64'(cur_reg.norm) * 64'(cur_reg.norm) + 64'sh8000) >>>
            msd_pkg::FRAC_W;
        // count interior points at or below the result
        k = '0;
        for (int i = 1; i < PTS_MAX - 1; i++) begin
            if (i < int'(I_POINT_COUNT) - 1 &&
                64'(cur_reg.norm) * 64'(msd_pkg::X_FULL) >=
                $signed(64'({cur_reg.pt_x[i], 16'h0000}))) begin
                k = k + 5'h01;
            end
        end
        ph = k + 5'h01;
        xdiff = signed'(11'(cur_reg.pt_x[ph])) -
            signed'(11'(cur_reg.pt_x[k]));
        ydiff = 17'(signed'(cur_reg.pt_y[ph])) -
            17'(signed'(cur_reg.pt_y[k]));
        // x in 0.1 % steps: the slope factor of 100 becomes x full scale
        num = (64'(cur_reg.norm) * 64'(msd_pkg::X_FULL) -
            $signed(64'({cur_reg.pt_x[k], 16'h0000}))) * 64'(ydiff);
        usr_bad = I_POINT_COUNT < 5'(msd_pkg::PTS_MIN) ||
            I_POINT_COUNT > 5'(PTS_MAX) || xdiff <= 11'sh000;
        cur_next = cur_reg;
        cur_next.done = 1'b0;
        if (I_POINT_WR && I_POINT_IDX < 5'(PTS_MAX)) begin
            cur_next.pt_x[I_POINT_IDX] = I_POINT_X;
            cur_next.pt_y[I_POINT_IDX] = I_POINT_Y;
        end
        case (cur_reg.st)
            msd_pkg::FSM_IDLE: begin
                if (I_SAMPLE_VALID) begin
                    cur_next.mode_4_20 = I_MODE_4_20;
                    cur_next.char_sel = I_CHAR_SEL;
                    cur_next.lo_c = I_CHARACTERISTIC_LOW_VALUE;
                    cur_next.hi_c = I_CHARACTERISTIC_HIGH_VALUE;
                    cur_next.diff_ua = cap_diff;
                    cur_next.range_st = range_code;
                    cur_next.usr_err = 1'b0;
                    mag = 64'(cap_diff < 0 ? -cap_diff : cap_diff);
                    cur_next.div_q = {mag[31:0], 16'h0000} +
                        48'(span >> 1);
                    cur_next.div_d = 32'(span);
                    cur_next.div_r = '0;
                    cur_next.div_neg = cap_diff < 0;
                    cur_next.cnt = msd_pkg::DIV_STEPS;
                    cur_next.busy = 1'b1;
                    cur_next.st = msd_pkg::FSM_NORM;
                end
            end
            msd_pkg::FSM_NORM, msd_pkg::FSM_INTERP: begin
                if (cur_reg.cnt != 6'h00) begin
                    if (rs >= {1'b0, cur_reg.div_d}) begin
                        cur_next.div_r = rs - {1'b0, cur_reg.div_d};
                        cur_next.div_q = {cur_reg.div_q[46:0], 1'b1};
                    end else begin
                        cur_next.div_r = rs;
                        cur_next.div_q = {cur_reg.div_q[46:0], 1'b0};
                    end
                    cur_next.cnt = cur_reg.cnt - 6'h01;
                end else begin
                    res = cur_reg.div_neg ? -signed'({1'b0, cur_reg.div_q}) :
                        signed'({1'b0, cur_reg.div_q});
                    if (cur_reg.st == msd_pkg::FSM_NORM) begin
                        cur_next.norm = 32'(res);
                        cur_next.st = msd_pkg::FSM_POST;
                    end else begin
                        cur_next.value = msd_sat16(64'(res) +
                            64'(cur_reg.ypl));
                        cur_next.st = msd_pkg::FSM_FINISH;
                    end
                end
            end
            msd_pkg::FSM_POST: begin
                cur_next.st = msd_pkg::FSM_FINISH;
                case (cur_reg.char_sel)
                    msd_pkg::CHAR_LIN: begin
                        cur_next.value = msd_scale(cur_reg.norm,
                            cur_reg.lo_c, cur_reg.hi_c);
                    end
                    msd_pkg::CHAR_SQR: begin
                        cur_next.value = msd_scale(32'(sq),
                            cur_reg.lo_c, cur_reg.hi_c);
                    end
                    msd_pkg::CHAR_SQRT: begin
                        if (cur_reg.norm < 0) begin
                            cur_next.value = cur_reg.lo_c;
                        end else begin
                            cur_next.rad = {cur_reg.norm, 16'h0000};
                            cur_next.root = '0;
                            cur_next.cnt = msd_pkg::SQRT_STEPS;
                            cur_next.st = msd_pkg::FSM_SQRT;
                        end
                    end
                    default: begin
                        if (usr_bad) begin
                            cur_next.usr_err = 1'b1;
                            cur_next.value = '0;
                        end else begin
                            mag = 64'(num < 0 ? -num : num);
                            cur_next.div_q = mag[47:0] +
                                48'({6'h00, xdiff, 15'h0000});
                            cur_next.div_d = {5'h00, xdiff, 16'h0000};
                            cur_next.div_r = '0;
                            cur_next.div_neg = num < 0;
                            cur_next.ypl = signed'(cur_reg.pt_y[k]);
                            cur_next.cnt = msd_pkg::DIV_STEPS;
                            cur_next.st = msd_pkg::FSM_INTERP;
                        end
                    end
                endcase
            end
            msd_pkg::FSM_SQRT: begin
                if (cur_reg.cnt != 6'h00) begin
                    if (48'(trial) * 48'(trial) <= cur_reg.rad) begin
                        cur_next.root = trial;
                    end
                    cur_next.cnt = cur_reg.cnt - 6'h01;
                end else begin
                    cur_next.value = msd_scale(32'({8'h00, cur_reg.root}),
                        cur_reg.lo_c, cur_reg.hi_c);
                    cur_next.st = msd_pkg::FSM_FINISH;
                end
            end
            msd_pkg::FSM_FINISH: begin
                cur_next.status = cur_reg.range_st != msd_pkg::STAT_VALID ?
                    cur_reg.range_st : cur_reg.usr_err ?
                    msd_pkg::STAT_USR_ERR : msd_pkg::STAT_VALID;
                cur_next.alarm = cur_reg.range_st != msd_pkg::STAT_VALID;
                cur_next.done = 1'b1;
                cur_next.busy = 1'b0;
                cur_next.st = msd_pkg::FSM_IDLE;
            end
            default: begin
                cur_next.st = msd_pkg::FSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            cur_reg <= RST_VAL;
        end else if (I_CE) begin
            cur_reg <= cur_next;
        end
    end

    assign O_VALUE = cur_reg.value;
    assign O_NORMALIZED = cur_reg.norm;
    assign O_STATUS = cur_reg.status;
    assign O_ALARM_LAMP = cur_reg.alarm;
    assign O_DONE = cur_reg.done;
    assign O_BUSY = cur_reg.busy;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_alarm_status;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        O_DONE |-> O_ALARM_LAMP == (O_STATUS == msd_pkg::STAT_ABOVE ||
            O_STATUS == msd_pkg::STAT_BELOW ||
            O_STATUS == msd_pkg::STAT_FAULT);
    endproperty
    a_alarm_status: assert property (p_alarm_status)
        else $error("alarm lamp disagrees with status");

    property p_fault_status;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        capture && (I_SENSOR_SHORT || I_SENSOR_OPEN) |-> ##[3:110]
            (O_DONE && O_STATUS == msd_pkg::STAT_FAULT && O_ALARM_LAMP);
    endproperty
    a_fault_status: assert property (p_fault_status)
        else $error("sensor fault not reported");

    property p_above_status;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        capture && !I_SENSOR_SHORT && !I_SENSOR_OPEN &&
            32'(I_CURRENT_UA) > lim_hi |-> ##[3:110]
            (O_DONE && O_STATUS == msd_pkg::STAT_ABOVE);
    endproperty
    a_above_status: assert property (p_above_status)
        else $error("upper border exit not reported");

    property p_diff_4_20;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        capture && I_MODE_4_20 |=> cur_reg.diff_ua ==
            signed'(17'($past(I_CURRENT_UA))) - 17'sh00FA0;
    endproperty
    a_diff_4_20: assert property (p_diff_4_20)
        else $error("4-20 offset wrong");

    property p_norm_0_20;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        capture && !I_MODE_4_20 |-> ##50 cur_reg.st == msd_pkg::FSM_POST &&
            64'(cur_reg.norm) * 64'sd20000 -
            ($signed(64'($past(I_CURRENT_UA, 50))) <<< 16) <= 64'sd10000 &&
            64'(cur_reg.norm) * 64'sd20000 -
            ($signed(64'($past(I_CURRENT_UA, 50))) <<< 16) >= -64'sd10000;
    endproperty
    a_norm_0_20: assert property (p_norm_0_20)
        else $error("0-20 normalization wrong");

    property p_sqrt_negative;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        cur_reg.st == msd_pkg::FSM_POST &&
            cur_reg.char_sel == msd_pkg::CHAR_SQRT && cur_reg.norm < 0
            |-> ##2 O_DONE && O_VALUE == $past(cur_reg.lo_c, 2);
    endproperty
    a_sqrt_negative: assert property (p_sqrt_negative)
        else $error("negative root not held at low value");

    property p_linear;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        cur_reg.st == msd_pkg::FSM_POST &&
            cur_reg.char_sel == msd_pkg::CHAR_LIN &&
            cur_reg.norm == 32'sh00010000 |-> ##2 O_DONE &&
            O_VALUE == $past(cur_reg.hi_c, 2);
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear value wrong");

    property p_square;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        cur_reg.st == msd_pkg::FSM_POST &&
            cur_reg.char_sel == msd_pkg::CHAR_SQR && cur_reg.norm == 0
            |-> ##2 O_DONE && O_VALUE == $past(cur_reg.lo_c, 2);
    endproperty
    a_square: assert property (p_square)
        else $error("square value wrong at zero");

    property p_user_count;
        @(posedge I_CORE_CLK) disable iff (I_RST || !I_CE)
        cur_reg.st == msd_pkg::FSM_POST &&
            cur_reg.char_sel == msd_pkg::CHAR_USER &&
            cur_reg.range_st == msd_pkg::STAT_VALID &&
            I_POINT_COUNT < 5'h02 |-> ##2 O_DONE &&
            O_STATUS == msd_pkg::STAT_USR_ERR;
    endproperty
    a_user_count: assert property (p_user_count)
        else $error("short user table not flagged");

endmodule : msd_scaling_datapath

`default_nettype wire

// ### dv/msd_front_end_model.sv
// front end model: offers one current sample per request
// assumes requests only while the datapath is idle
`default_nettype none

module msd_front_end_model (
    // clock and request from the bench
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic [15:0] i_cur,
    input wire logic [1:0] i_flt,
    // sample lines
    output logic o_valid,
    output logic [15:0] o_cur,
    output logic o_short,
    output logic o_open
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_valid = 1'b0;
        o_cur = 16'h0000;
        o_short = 1'b0;
        o_open = 1'b0;
    end

    always @(posedge i_clk) begin
        if (i_req) begin
            o_valid <= 1'b1;
            o_cur <= i_cur;
            {o_short, o_open} <= i_flt;
        end else if (o_valid) begin
            // released valid and current lines show the inverse of the last value; fault lines hold
            o_valid <= 1'b0;
            o_cur <= ~o_cur;
        end
    end
endmodule : msd_front_end_model

`default_nettype wire

// ### dv/measurement_scaling_datapath_test.sv
// bench: sample sequences against the scaling datapath
// assumes msd_pkg and the front end model are compiled first
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module measurement_scaling_datapath_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // stimulus and results
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic [15:0] cur = 16'h0000;
    logic [1:0] flt = 2'h0;
    logic mode = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [15:0] lo = 16'h0000;
    logic [15:0] hi = 16'h0000;
    logic [4:0] pc = 5'h00;
    logic wr = 1'b0;
    logic [4:0] idx = 5'h00;
    logic [9:0] px = 10'h000;
    logic [15:0] py = 16'h0000;
    logic ce = 1'b1;
    logic [9:0] xlo = 10'h0C8;
    logic [9:0] xhi = 10'h064;
    logic sv, ss, so, done, busy, alarm;
    logic [15:0] cu, val;
    logic [31:0] nrm;
    logic [7:0] st;
    logic [7:0] k_ok = msd_pkg::STAT_VALID;
    logic [7:0] k_hi = msd_pkg::STAT_ABOVE;
    logic [7:0] k_lo = msd_pkg::STAT_BELOW;
    logic [7:0] k_ft = msd_pkg::STAT_FAULT;
    logic [7:0] k_ue = msd_pkg::STAT_USR_ERR;
    logic [1:0] s_lin = msd_pkg::CHAR_LIN;
    logic [1:0] s_sqr = msd_pkg::CHAR_SQR;
    logic [1:0] s_rt = msd_pkg::CHAR_SQRT;
    logic [1:0] s_usr = msd_pkg::CHAR_USER;
    int fail_count = 0;
    int n_tests = 0;

    always #12.5 clk = ~clk;

    msd_front_end_model u_fe (
        .i_clk(clk), .i_req(req), .i_cur(cur), .i_flt(flt),
        .o_valid(sv), .o_cur(cu), .o_short(ss), .o_open(so)
    );

    msd_scaling_datapath u_dut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce),
        .I_SAMPLE_VALID(sv), .I_CURRENT_UA(cu),
        .I_SENSOR_SHORT(ss), .I_SENSOR_OPEN(so),
        .I_MODE_4_20(mode), .I_CHAR_SEL(sel),
        .I_CHARACTERISTIC_LOW_VALUE(lo),
        .I_CHARACTERISTIC_HIGH_VALUE(hi),
        .I_RANGE_LOW_EXTENSION_PCT(xlo),
        .I_RANGE_HIGH_EXTENSION_PCT(xhi),
        .I_POINT_COUNT(pc), .I_POINT_WR(wr), .I_POINT_IDX(idx),
        .I_POINT_X(px), .I_POINT_Y(py),
        .O_VALUE(val), .O_NORMALIZED(nrm), .O_STATUS(st),
        .O_ALARM_LAMP(alarm), .O_DONE(done), .O_BUSY(busy)
    );
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wp(input logic [4:0] i, input logic [9:0] x,
                      input logic [15:0] y);
        @(posedge clk);
        wr <= 1'b1;
        idx <= i;
        px <= x;
        py <= y;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wp

    // one sample; checks latency, value, status and lamp
    task automatic run(input logic [1:0] s, input logic [15:0] c,
                       input logic [1:0] f, input logic [7:0] es,
                       input logic [15:0] ev, input int lat);
        int n;
        // done set by edge c51 is sampled high at edge c52
        n = 1;
        @(posedge clk);
        req <= 1'b1;
        sel <= s;
        cur <= c;
        flt <= f;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(busy, 1'b1)
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 200);
        `CHK(n, lat)
        `CHK(val, ev)
        `CHK(st, es)
        `CHK(busy, 1'b0)
        `CHK(alarm, (es == k_hi || es == k_lo || es == k_ft))
    endtask : run
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(st, msd_pkg::STAT_WAIT)
        `CHK({alarm, busy, done, val}, 19'h00000)
        lo <= 16'hFED4;
        hi <= 16'h0514;
        run(s_lin, 16'h2EE0, 2'h0, k_ok, 16'h01F4, 52);
        `CHK(nrm, 32'h00008000)
        run(s_sqr, 16'h2EE0, 2'h0, k_ok, 16'h0064, 52);
        run(s_rt, 16'h1F40, 2'h0, k_ok, 16'h01F4, 77);
        run(s_rt, 16'h0E10, 2'h0, k_ok, 16'hFED4, 52);
        lo <= 16'h0514;
        hi <= 16'hFED4;
        run(s_lin, 16'h3E80, 2'h0, k_ok, 16'h0064, 52);
        lo <= 16'h0064;
        hi <= 16'h01F4;
        mode <= 1'b0;
        run(s_lin, 16'h1388, 2'h0, k_ok, 16'h00C8, 52);
        `CHK(nrm, 32'h00004000)
        lo <= 16'h0000;
        hi <= 16'h0640;
        mode <= 1'b1;
        run(s_lin, 16'h55F0, 2'h0, k_ok, 16'h0708, 52);
        `CHK(nrm, 32'h00012000)
        run(s_lin, 16'h55F1, 2'h0, k_hi, 16'h0708, 52);
        run(s_lin, 16'h0C80, 2'h0, k_ok, 16'hFFB0, 52);
        run(s_lin, 16'h0C7F, 2'h0, k_lo, 16'hFFB0, 52);
        run(s_lin, 16'h2EE0, 2'h2, k_ft, 16'h0320, 52);
        run(s_lin, 16'h2EE0, 2'h1, k_ft, 16'h0320, 52);
        run(s_lin, 16'h4E20, 2'h0, k_ok, 16'h0640, 52);
        run(s_sqr, 16'h0FA0, 2'h0, k_ok, 16'h0000, 52);
        // enable low for three edges mid divide stretches the run by three
        fork
            run(s_lin, 16'h2EE0, 2'h0, k_ok, 16'h0320, 55);
            begin
                repeat (10) @(posedge clk);
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        xlo <= 10'h000;
        xhi <= 10'h000;
        run(s_lin, 16'h4E21, 2'h0, k_hi, 16'h0640, 52);
        run(s_lin, 16'h0F9F, 2'h0, k_lo, 16'h0000, 52);
        xlo <= 10'h0C8;
        xhi <= 10'h064;
        wp(5'h00, 10'h000, 16'h0000);
        wp(5'h01, 10'h1F4, 16'h03E8);
        wp(5'h02, 10'h3E8, 16'h05DC);
        pc <= 5'h03;
        run(s_usr, 16'h3E80, 2'h0, k_ok, 16'h04E2, 101);
        run(s_usr, 16'h55F0, 2'h0, k_ok, 16'h0659, 101);
        run(s_usr, 16'h0C80, 2'h0, k_ok, 16'hFF9C, 101);
        pc <= 5'h02;
        run(s_usr, 16'h3E80, 2'h0, k_ok, 16'h05DC, 101);
        pc <= 5'h01;
        run(s_usr, 16'h3E80, 2'h0, k_ue, 16'h0000, 52);
        pc <= 5'h15;
        run(s_usr, 16'h3E80, 2'h0, k_ue, 16'h0000, 52);
        pc <= 5'h02;
        // second reset: status waits again and the table is cleared
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({st, nrm}, {msd_pkg::STAT_WAIT, 32'h00000000})
        run(s_usr, 16'h3E80, 2'h0, k_ue, 16'h0000, 52);
        tally_and_finish();
    end
endmodule : measurement_scaling_datapath_test

`default_nettype wire
